// [rtl/virq_map.svh]
// Register offsets, field positions and reset values of the vectored interrupt state block
`ifndef VIRQ_MAP_SVH
`define VIRQ_MAP_SVH
`define VIRQ_OFS_ENA_SET_LO    12'h000
`define VIRQ_OFS_ENA_SET_HI    12'h004
`define VIRQ_OFS_ENA_CLR_LO    12'h080
`define VIRQ_OFS_ENA_CLR_HI    12'h084
`define VIRQ_OFS_PEND_SET_LO   12'h100
`define VIRQ_OFS_PEND_SET_HI   12'h104
`define VIRQ_OFS_PEND_CLR_LO   12'h180
`define VIRQ_OFS_PEND_CLR_HI   12'h184
`define VIRQ_OFS_ACT_LO        12'h200
`define VIRQ_OFS_ACT_HI        12'h204
`define VIRQ_OFS_TGT_LO        12'h280
`define VIRQ_OFS_TGT_HI        12'h284
`define VIRQ_OFS_PRIO_BASE     12'h300
`define VIRQ_OFS_PRIO_LAST     12'h33C
`define VIRQ_OFS_CTRL          12'h400
`define VIRQ_OFS_IRQ_STAT      12'h404
`define VIRQ_OFS_IRQ_MASK      12'h408
`define VIRQ_OFS_CLAIM         12'h40C
`define VIRQ_OFS_DONE          12'h410
`define VIRQ_PRIO_FIELD_LSB    6
`define VIRQ_PRIO_FIELD_STEP   8
`define VIRQ_CTRL_SHIFT_BIT    0
`define VIRQ_RESET_WORD        32'h0000_0000
`define VIRQ_NS_SHIFT_BASE     8'h80
`define VIRQ_NO_IRQ_ID         8'hFF
`endif

// [rtl/virq_pkg.sv]
// Types shared by the vectored interrupt state block
package virq_pkg;
	typedef logic [31:0] virq_word_t;
	typedef logic [11:0] virq_addr_t;
	typedef logic [7:0]  virq_level_t;
endpackage

// [rtl/virq_state_regs.sv]
// Vectored interrupt state registers with Avalon-MM slave and priority selection
//
// Functional notes
// - A one written to an enable-clear bit disables that interrupt; reads show enabled ones.
// - A one written to a pending-set bit makes that interrupt pending; reads show pending ones.
// - A one written to a pending-clear bit removes pending state; reads show pending ones.
// - Active-status words read one for each interrupt being serviced.
// - A target-state bit of zero routes to Secure, one routes to Non-secure.
// - Target-state words read zero and ignore writes when accessed as Non-secure.
// - Sixty-four interrupts sit in word pairs, bit n of the second word being interrupt 32+n.
// - Sixteen priority words at 0x300 plus four times n cover interrupts 4n to 4n+3.
// - Each priority word holds 2-bit fields at bits 7:6, 15:14, 23:22 and 31:30, rest reserved.
// - Fields map to 0,64,128,192, or for Non-secure with shift set to 128,160,192,224.
// - All enable, pending, active, target and priority state reads zero after reset.
`timescale 1ns/1ps
`include "virq_map.svh"
`default_nettype none
module virq_state_regs
	import virq_pkg::*;
#(
	parameter int NUM_IRQ = 64
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               nrst_i,
	// Avalon-MM slave
	input  wire virq_pkg::virq_addr_t avs_address_i,
	input  wire logic               avs_read_i,
	input  wire logic               avs_write_i,
	input  wire virq_pkg::virq_word_t avs_writedata_i,
	input  wire logic [3:0]         avs_byteenable_i,
	input  wire logic               avs_nonsecure_i,
	output logic                    avs_waitrequest_o,
	output virq_pkg::virq_word_t    avs_readdata_o,
	output logic [1:0]              avs_response_o,
	// Peripheral request lines, one per interrupt, same clock
	input  wire logic [63:0]        irq_req_i,
	// Core side
	output logic                    core_irq_o,
	output logic [7:0]              core_irq_id_o,
	output logic [7:0]              core_irq_level_o,
	output logic                    core_irq_nonsecure_o,
	// Block interrupt
	output logic                    intr_o
);
	import virq_pkg::*;

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic rst_s1_reg;
	logic rst_n;
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	// One wait cycle per access keeps read data registered
	logic ack_reg;
	wire  req      = avs_read_i | avs_write_i;
	wire  acc      = req & ack_reg;
	wire  wr       = avs_write_i & acc;
	wire  rd       = avs_read_i & acc;
	wire  [31:0] bemask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
	                       {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	wire  [31:0] wd     = avs_writedata_i & bemask;
	wire  [11:0] a      = avs_address_i;
	wire  hi_word  = a[2];
	wire  [11:0] a_lo = {a[11:3], 3'b000};
	wire  sel_ena_set  = (a_lo == `VIRQ_OFS_ENA_SET_LO);
	wire  sel_ena_clr  = (a_lo == `VIRQ_OFS_ENA_CLR_LO);
	wire  sel_pend_set = (a_lo == `VIRQ_OFS_PEND_SET_LO);
	wire  sel_pend_clr = (a_lo == `VIRQ_OFS_PEND_CLR_LO);
	wire  sel_act      = (a_lo == `VIRQ_OFS_ACT_LO);
	wire  sel_tgt      = (a_lo == `VIRQ_OFS_TGT_LO);
	wire  sel_prio     = (a >= `VIRQ_OFS_PRIO_BASE) && (a <= `VIRQ_OFS_PRIO_LAST)
	                     && (a[1:0] == 2'b00);
	wire  [3:0] prio_idx = a[5:2];
	wire  sel_ctrl     = (a == `VIRQ_OFS_CTRL);
	wire  sel_stat     = (a == `VIRQ_OFS_IRQ_STAT);
	wire  sel_mask     = (a == `VIRQ_OFS_IRQ_MASK);
	wire  sel_claim    = (a == `VIRQ_OFS_CLAIM);
	wire  sel_done     = (a == `VIRQ_OFS_DONE);
	wire  mapped = sel_ena_set | sel_ena_clr | sel_pend_set | sel_pend_clr | sel_act
	             | sel_tgt | sel_prio | sel_ctrl | sel_stat | sel_mask | sel_claim | sel_done;
	// Word of 64-bit vectors that a write to this offset touches
	wire  [63:0] wd64 = hi_word ? {wd, 32'h0000_0000} : {32'h0000_0000, wd};

	assign avs_waitrequest_o = req & ~ack_reg;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) ack_reg <= 1'b0;
		else        ack_reg <= req & ~ack_reg;
	end

	// ****************************************************************
	// Interrupt state
	// ****************************************************************
	logic [63:0] enable_reg, enable_next;
	logic [63:0] pend_reg, pend_next;
	logic [63:0] active_reg, active_next;
	logic [63:0] target_state_bits;
	logic [1:0]  irq_priority_field [NUM_IRQ];
	logic        nonsecure_priority_shift;
	logic        claim_pulse;
	logic        done_pulse;
	logic [7:0]  done_id;
	logic [7:0]  best_id;
	logic        best_valid;

	wire  [63:0] enable_clear_bits  = (wr & sel_ena_clr)  ? wd64 : 64'h0;
	wire  [63:0] enable_set_bits    = (wr & sel_ena_set)  ? wd64 : 64'h0;
	wire  [63:0] pending_set_bits   = (wr & sel_pend_set) ? wd64 : 64'h0;
	wire  [63:0] pending_clear_bits = (wr & sel_pend_clr) ? wd64 : 64'h0;
	wire  [63:0] claim_onehot = (claim_pulse & best_valid) ? (64'h1 << best_id[5:0]) : 64'h0;
	wire  [63:0] done_onehot  = done_pulse ? (64'h1 << done_id[5:0]) : 64'h0;

	assign claim_pulse = rd & sel_claim;
	assign done_pulse  = wr & sel_done;
	assign done_id     = wd[7:0];

	always_comb begin
		enable_next = (enable_reg | enable_set_bits) & ~enable_clear_bits;
		// Hardware requests and software sets win over a clear in the same cycle
		pend_next   = ((pend_reg & ~pending_clear_bits & ~claim_onehot)
		              | pending_set_bits | irq_req_i);
		active_next = (active_reg & ~done_onehot) | claim_onehot;
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			enable_reg <= 64'h0;
			pend_reg   <= 64'h0;
			active_reg <= 64'h0;
		end else begin
			enable_reg <= enable_next;
			pend_reg   <= pend_next;
			active_reg <= active_next;
		end
	end

	// Target state is Secure-only
	wire tgt_wr = wr & sel_tgt & ~avs_nonsecure_i;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n)      target_state_bits <= 64'h0;
		else if (tgt_wr) target_state_bits <= hi_word ? {wd, target_state_bits[31:0]}
		                                              : {target_state_bits[63:32], wd};
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n)                nonsecure_priority_shift <= 1'b0;
		else if (wr & sel_ctrl & avs_byteenable_i[0])
			nonsecure_priority_shift <= avs_writedata_i[`VIRQ_CTRL_SHIFT_BIT];
	end

	// ****************************************************************
	// Priority fields and level mapping
	// ****************************************************************
	logic [7:0] level [NUM_IRQ];
	genvar g;
	generate
		for (g = 0; g < NUM_IRQ; g++) begin : g_prio
			localparam int FLSB = `VIRQ_PRIO_FIELD_LSB + `VIRQ_PRIO_FIELD_STEP * (g % 4);
			wire hit = wr & sel_prio & (prio_idx == 4'(g / 4)) & avs_byteenable_i[g % 4];
			always_ff @(posedge clk_i or negedge rst_n) begin
				if (!rst_n)   irq_priority_field[g] <= 2'b00;
				else if (hit) irq_priority_field[g] <= wd[FLSB +: 2];
			end
			// Field value times 64, or Non-secure shifted into 128..224
			wire [7:0] base_lvl  = {irq_priority_field[g], 6'b00_0000};
			wire [7:0] shift_lvl = `VIRQ_NS_SHIFT_BASE | {1'b0, irq_priority_field[g], 5'b0_0000};
			assign level[g] = (target_state_bits[g] & nonsecure_priority_shift)
			                  ? shift_lvl : base_lvl;
		end
	endgenerate

	// ****************************************************************
	// Candidate selection
	// ****************************************************************
	// Linear scan; lowest index wins a tie, traded area for a long combinational path
	wire [63:0] cand = enable_reg & pend_reg;
	always_comb begin
		best_valid = 1'b0;
		best_id    = `VIRQ_NO_IRQ_ID;
		for (int i = 0; i < NUM_IRQ; i++) begin
			if (cand[i] && (!best_valid || (level[i] < level[best_id[5:0]]))) begin
				best_valid = 1'b1;
				best_id    = 8'(i);
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			core_irq_o           <= 1'b0;
			core_irq_id_o        <= `VIRQ_NO_IRQ_ID;
			core_irq_level_o     <= 8'h00;
			core_irq_nonsecure_o <= 1'b0;
		end else begin
			core_irq_o           <= best_valid;
			core_irq_id_o        <= best_id;
			core_irq_level_o     <= best_valid ? level[best_id[5:0]] : 8'h00;
			core_irq_nonsecure_o <= best_valid & target_state_bits[best_id[5:0]];
		end
	end

	// ****************************************************************
	// Block interrupt: sticky events on new candidate and on claim
	// ****************************************************************
	logic [1:0] stat_reg;
	logic [1:0] mask_reg;
	logic       had_cand_reg;
	wire  [1:0] ev     = {claim_pulse & best_valid, best_valid & ~had_cand_reg};
	wire  [1:0] st_clr = (wr & sel_stat & avs_byteenable_i[0]) ? avs_writedata_i[1:0] : 2'b00;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stat_reg     <= 2'b00;
			mask_reg     <= 2'b00;
			had_cand_reg <= 1'b0;
		end else begin
			stat_reg     <= (stat_reg & ~st_clr) | ev;
			had_cand_reg <= best_valid;
			if (wr & sel_mask & avs_byteenable_i[0]) mask_reg <= avs_writedata_i[1:0];
		end
	end
	assign intr_o = |(stat_reg & mask_reg);

	// ****************************************************************
	// Read data
	// ****************************************************************
	wire [31:0] pick_en  = hi_word ? enable_reg[63:32] : enable_reg[31:0];
	wire [31:0] pick_pd  = hi_word ? pend_reg[63:32]   : pend_reg[31:0];
	wire [31:0] pick_ac  = hi_word ? active_reg[63:32] : active_reg[31:0];
	wire [31:0] pick_tg  = avs_nonsecure_i ? 32'h0000_0000
	                     : (hi_word ? target_state_bits[63:32] : target_state_bits[31:0]);
	wire [5:0]  pb       = {prio_idx, 2'b00};
	wire [31:0] pick_pr  = {irq_priority_field[pb + 6'd3], 6'h00, irq_priority_field[pb + 6'd2],
	                        6'h00, irq_priority_field[pb + 6'd1], 6'h00,
	                        irq_priority_field[pb], 6'h00};
	wire [31:0] rdata =
		(sel_ena_set | sel_ena_clr)   ? pick_en :
		(sel_pend_set | sel_pend_clr) ? pick_pd :
		sel_act   ? pick_ac :
		sel_tgt   ? pick_tg :
		sel_prio  ? pick_pr :
		sel_ctrl  ? {31'h0, nonsecure_priority_shift} :
		sel_stat  ? {30'h0, stat_reg} :
		sel_mask  ? {30'h0, mask_reg} :
		sel_claim ? {24'h0, best_id} : `VIRQ_RESET_WORD;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata_o <= 32'h0000_0000;
			avs_response_o <= 2'b00;
		end else if (req & ~ack_reg) begin
			avs_readdata_o <= avs_read_i ? rdata : 32'h0000_0000;
			avs_response_o <= mapped ? 2'b00 : 2'b11;
		end
	end

	// ****************************************************************
	// Checks: bus protocol
	// ****************************************************************
	// Answer timing is fixed, so a waiting master never stalls longer than one cycle
	chk_wait_one_cycle: assert property (@(posedge clk_i) disable iff (!rst_n)
		avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("waitrequest held longer than one cycle");
	chk_resp_mapped: assert property (@(posedge clk_i) disable iff (!rst_n)
		(req & ~ack_reg & mapped) |=> avs_response_o == 2'b00)
		else $error("mapped access answered with error");
	chk_resp_unmapped: assert property (@(posedge clk_i) disable iff (!rst_n)
		(req & ~ack_reg & ~mapped) |=> avs_response_o == 2'b11)
		else $error("unmapped access answered as good");
	chk_ns_read_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
		(req & ~ack_reg & avs_read_i & sel_tgt & avs_nonsecure_i)
		|=> avs_readdata_o == 32'h0000_0000)
		else $error("non-secure target read not zero");

	// ****************************************************************
	// Checks: interrupt state
	// ****************************************************************
	chk_enable_clear: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr & sel_ena_clr & ~hi_word & wd[0]) |=> !enable_reg[0])
		else $error("enable bit survived clear");
	chk_enable_clr_hi: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr & sel_ena_clr & hi_word & wd[0]) |=> !enable_reg[32])
		else $error("upper enable bit survived clear");
	// Zeros in a clear word must leave their enables alone
	chk_clear_only_ones: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr & sel_ena_clr) |=> enable_reg == ($past(enable_reg) & ~$past(enable_clear_bits)))
		else $error("enable clear touched a zero bit");
	chk_enable_set_hi: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr & sel_ena_set & hi_word & wd[0]) |=> enable_reg[32])
		else $error("upper enable set lost");
	chk_pending_set: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr & sel_pend_set & hi_word & wd[0]) |=> pend_reg[32])
		else $error("pending set lost");
	chk_pend_set_keep: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr & sel_pend_set) |=> (pend_reg & $past(pend_reg)) == $past(pend_reg))
		else $error("pending set word removed a pending bit");
	chk_pending_clear: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr & sel_pend_clr & ~hi_word & wd[1] & ~irq_req_i[1]) |=> !pend_reg[1])
		else $error("pending clear ignored");
	chk_pend_clear_keep: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr & sel_pend_clr) |=> ((pend_reg ^ $past(pend_reg))
		& ~$past(pending_clear_bits) & ~$past(irq_req_i)) == 64'h0)
		else $error("pending clear word changed an untouched bit");
	chk_active_claim: assert property (@(posedge clk_i) disable iff (!rst_n)
		(claim_pulse & best_valid) |=> active_reg[$past(best_id[5:0])])
		else $error("claimed interrupt not active");
	chk_active_done: assert property (@(posedge clk_i) disable iff (!rst_n)
		done_pulse |=> !active_reg[$past(done_id[5:0])])
		else $error("finished interrupt still active");
	chk_active_no_claim: assert property (@(posedge clk_i) disable iff (!rst_n)
		!claim_pulse |=> (active_reg & ~$past(active_reg)) == 64'h0)
		else $error("interrupt became active without a claim");
	chk_claim_unpend: assert property (@(posedge clk_i) disable iff (!rst_n)
		(claim_pulse & best_valid & ~irq_req_i[best_id[5:0]]) |=> !pend_reg[$past(best_id[5:0])])
		else $error("claimed interrupt still pending");
	chk_target_secure_wr: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr & sel_tgt & ~avs_nonsecure_i & ~hi_word) |=> target_state_bits[31:0] == $past(wd))
		else $error("secure target write lost");
	chk_target_ns_wi: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr & sel_tgt & avs_nonsecure_i) |=> $stable(target_state_bits))
		else $error("non-secure write changed target");
	chk_prio_field: assert property (@(posedge clk_i) disable iff (!rst_n)
		(wr & sel_prio & (prio_idx == 4'h0) & avs_byteenable_i[1])
		|=> irq_priority_field[1] == $past(wd[15:14]))
		else $error("priority field not written");
	chk_prio_reserved: assert property (@(posedge clk_i) disable iff (!rst_n)
		(req & ~ack_reg & avs_read_i & sel_prio)
		|=> (avs_readdata_o & 32'h3F3F_3F3F) == 32'h0000_0000)
		else $error("reserved priority bits not zero");
	chk_reset_clean: assert property (@(posedge clk_i)
		$rose(rst_n) |-> (enable_reg == 64'h0) && (pend_reg == 64'h0) && (active_reg == 64'h0))
		else $error("state not zero after reset");
	chk_stat_sticky: assert property (@(posedge clk_i) disable iff (!rst_n)
		ev[1] |=> stat_reg[1])
		else $error("claim event lost against a clear");

	// ****************************************************************
	// Checks: core side
	// ****************************************************************
	chk_level_map: assert property (@(posedge clk_i) disable iff (!rst_n)
		(target_state_bits[4] & nonsecure_priority_shift & (irq_priority_field[4] == 2'b01))
		|-> level[4] == 8'd160)
		else $error("shifted level wrong");
	chk_level_unshifted: assert property (@(posedge clk_i) disable iff (!rst_n)
		!(target_state_bits[4] & nonsecure_priority_shift)
		|-> level[4] == 8'(64 * irq_priority_field[4]))
		else $error("unshifted level wrong");
	// Core outputs are registered, so they are held against last cycle's state
	chk_target_route: assert property (@(posedge clk_i) disable iff (!rst_n)
		core_irq_o |-> core_irq_nonsecure_o
		== |($past(target_state_bits) & (64'h1 << core_irq_id_o[5:0])))
		else $error("target route mismatch");
	chk_offer_gate: assert property (@(posedge clk_i) disable iff (!rst_n)
		core_irq_o |-> |($past(cand) & (64'h1 << core_irq_id_o[5:0])))
		else $error("offered unqualified interrupt");
	chk_offer_none: assert property (@(posedge clk_i) disable iff (!rst_n)
		!core_irq_o |-> core_irq_id_o == `VIRQ_NO_IRQ_ID)
		else $error("idle core side shows an id");
	chk_offer_lowest_lo: assert property (@(posedge clk_i) disable iff (!rst_n)
		(core_irq_o & $past(cand[4])) |-> core_irq_level_o <= $past(level[4]))
		else $error("lower word candidate outranked");
	chk_offer_lowest_hi: assert property (@(posedge clk_i) disable iff (!rst_n)
		(core_irq_o & $past(cand[32])) |-> core_irq_level_o <= $past(level[32]))
		else $error("upper word candidate outranked");
	cov_claim: cover property (@(posedge clk_i) disable iff (!rst_n) claim_pulse & best_valid);
	cov_ns_shift: cover property (@(posedge clk_i) disable iff (!rst_n)
		core_irq_o & core_irq_nonsecure_o & nonsecure_priority_shift);
	cov_intr: cover property (@(posedge clk_i) disable iff (!rst_n) intr_o);
	cov_two_cand: cover property (@(posedge clk_i) disable iff (!rst_n) cand[4] & cand[32]);
	cov_unmapped: cover property (@(posedge clk_i) disable iff (!rst_n) req & ~ack_reg & ~mapped);
endmodule
`default_nettype wire

// [testbench/virq_periph_model.sv]
// Peripheral request line model for the vectored interrupt state bench
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Peripheral side
// ****************************************
module virq_periph_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// Command from the bench
	input  wire logic [63:0] fire_i,
	// Request lines
	output logic      [63:0] irq_req_o
);
	// Registered so each command reaches the block one cycle later, for as many cycles as fire_i holds it
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_req_o <= 64'h0;
		end else begin
			irq_req_o <= fire_i;
		end
	end
endmodule
`default_nettype wire

// [testbench/tb_virq_state_regs.sv]
// Self-checking bench for the vectored interrupt state registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_virq_state_regs;
	import virq_pkg::*;
	// ****************************************
	// Signals
	// ****************************************
	logic        clk_i;
	logic        nrst_i;
	virq_addr_t  adr;
	logic        rd;
	logic        wr;
	logic        ns;
	logic        wait_o;
	virq_word_t  wdat;
	virq_word_t  rdat;
	virq_word_t  q;
	logic [1:0]  rsp;
	logic [1:0]  rsp_q;
	logic [63:0] fire;
	logic [63:0] irq_req;
	logic        cirq;
	logic        cns;
	logic        intr;
	logic [7:0]  cid;
	logic [7:0]  clvl;
	virq_level_t el;
	int          bad_count;
	int          samples_checked;
	int          m;
	int          f;
	virq_addr_t  offs [9] = '{12'h084, 12'h100, 12'h104, 12'h180, 12'h184,
		12'h200, 12'h204, 12'h280, 12'h284};
	virq_addr_t  clr [4] = '{12'h080, 12'h084, 12'h180, 12'h184};
	virq_state_regs virq_state_regs_i (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
		.avs_nonsecure_i(ns), .avs_waitrequest_o(wait_o), .avs_readdata_o(rdat),
		.avs_response_o(rsp), .irq_req_i(irq_req), .core_irq_o(cirq), .core_irq_id_o(cid),
		.core_irq_level_o(clvl), .core_irq_nonsecure_o(cns), .intr_o(intr));
	virq_periph_model virq_periph_model_i (.clk_i(clk_i), .nrst_i(nrst_i), .fire_i(fire),
		.irq_req_o(irq_req));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic conclude();
		$display("checked=%0d mismatches=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Request stands until the rising edge that samples waitrequest low
	task automatic acc(input logic w, input virq_addr_t a, input virq_word_t d, input logic s);
		int n;
		@(posedge clk_i);
		adr <= a;
		wr <= w;
		rd <= ~w;
		wdat <= d;
		ns <= s;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (wait_o === 1'b0) break;
		end
		if (n == 20) begin
			bad_count++;
			conclude();
		end
		q = rdat;
		rsp_q = rsp;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic wrt(input virq_addr_t a, input virq_word_t d, input logic s = 1'b0);
		acc(1'b1, a, d, s);
	endtask
	task automatic rdc(input virq_addr_t a, input virq_word_t e, input logic s = 1'b0);
		acc(1'b0, a, 32'h0, s);
		`CHK(q, e)
	endtask
	// Core outputs trail the register update by one cycle
	task automatic settle();
		repeat (2) @(negedge clk_i);
	endtask
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		nrst_i = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		ns = 1'b0;
		adr = 12'h0;
		wdat = 32'h0;
		fire = 64'h0;
		bad_count = 0;
		samples_checked = 0;
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		for (m = 0; m < 9; m++) begin
			rdc(offs[m], 32'h0);
		end
		for (m = 0; m < 16; m++) begin
			rdc(12'h300 + 12'(4 * m), 32'h0);
		end
		`CHK(cid, 8'hFF)
		`CHK(intr, 1'b0)
		wrt(12'h004, 32'hFFFF_FFFF);
		wrt(12'h084, 32'h0000_0005);
		wrt(12'h084, 32'h0);
		rdc(12'h084, 32'hFFFF_FFFA);
		`CHK(rsp_q, 2'b00)
		wrt(12'h100, 32'h0000_0011);
		wrt(12'h104, 32'h0000_0001);
		wrt(12'h100, 32'h0);
		rdc(12'h100, 32'h0000_0011);
		rdc(12'h184, 32'h0000_0001);
		wrt(12'h180, 32'h0000_0001);
		rdc(12'h180, 32'h0000_0010);
		wrt(12'h280, 32'hA5A5_0000);
		wrt(12'h280, 32'hFFFF_FFFF, 1'b1);
		rdc(12'h280, 32'hA5A5_0000);
		rdc(12'h280, 32'h0, 1'b1);
		for (m = 0; m < 16; m++) begin
			wrt(12'h300 + 12'(4 * m), 32'hFFFF_FFFF);
			rdc(12'h300 + 12'(4 * m), 32'hC0C0_C0C0);
			wrt(12'h300 + 12'(4 * m), 32'h0);
		end
		for (m = 0; m < 4; m++) begin
			wrt(clr[m], 32'hFFFF_FFFF);
		end
		wrt(12'h000, 32'h0000_0010);
		wrt(12'h100, 32'h0000_0010);
		// Secure, Non-secure without shift, Non-secure with shift
		for (m = 0; m < 3; m++) begin
			wrt(12'h280, {27'h0, m != 0, 4'h0});
			wrt(12'h400, {31'h0, m == 2});
			for (f = 0; f < 4; f++) begin
				wrt(12'h304, 32'(f) << 6);
				settle();
				el = (m == 2) ? 8'(128 + 32 * f) : 8'(64 * f);
				`CHK(clvl, el)
				`CHK(cns, m != 0)
				`CHK(cid, 8'h04)
				`CHK(cirq, 1'b1)
			end
		end
		wrt(12'h280, 32'h0);
		wrt(12'h400, 32'h0);
		wrt(12'h004, 32'h1);
		wrt(12'h104, 32'h1);
		wrt(12'h320, 32'h40);
		settle();
		`CHK(cid, 8'h20)
		wrt(12'h304, 32'h0);
		settle();
		`CHK(cid, 8'h04)
		wrt(12'h080, 32'h10);
		settle();
		`CHK(cid, 8'h20)
		`CHK(clvl, 8'h40)
		wrt(12'h408, 32'h0);
		rdc(12'h40C, 32'h20);
		rdc(12'h204, 32'h1);
		rdc(12'h104, 32'h0);
		`CHK(cirq, 1'b0)
		`CHK(intr, 1'b0)
		wrt(12'h408, 32'h2);
		settle();
		`CHK(intr, 1'b1)
		wrt(12'h404, 32'h3);
		settle();
		`CHK(intr, 1'b0)
		wrt(12'h410, 32'h20);
		rdc(12'h204, 32'h0);
		@(posedge clk_i);
		fire <= 64'h1 << 40;
		@(posedge clk_i);
		fire <= 64'h0;
		rdc(12'h104, 32'h0000_0100);
		// Reset in mid-run: state written above must read zero again
		@(posedge clk_i);
		nrst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rdc(12'h104, 32'h0);
		rdc(12'h084, 32'h0);
		rdc(12'h320, 32'h0);
		wrt(12'h184, 32'h100);
		rdc(12'h184, 32'h0);
		rdc(12'h500, 32'h0);
		`CHK(rsp_q, 2'b11)
		conclude();
	end
endmodule
`default_nettype wire
